/* File: rtl/drds_core.v */
// Read data recovery, address mark gating, lock-up control and bit clock
`include "drds_defs.vh"
`default_nettype none
module drds_core #(
   parameter [15:0] LOCK_PRESET = `DRDS_LOCK_RST,
   parameter [15:0] MARK_QUAL   = `DRDS_QUAL_RST,
   parameter [15:0] MARK_TIME   = `DRDS_MTIM_RST,
   parameter [15:0] FREQ_WORD   = `DRDS_FREQ_WORD
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   output reg  [1:0]  s_axi_bresp,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [7:0]  s_axi_araddr,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   input  wire        cmp_out,
   input  wire        read_window_gate,
   input  wire        servo_reference_osc,
   input  wire        heads_loaded,
   output reg         mark_found_flag,
   output reg         read_data_out,
   output reg         rw_clock,
   output reg         clk_2f,
   output reg         clk_2f_n,
   output reg         clk_f,
   output reg         clk_f_n,
   output reg         phase_compare_clock,
   output reg         correction_pulse,
   output reg         correction_up
);

   // ==========================================
   // Derived timing
   localparam integer DLY_RAW = (`DRDS_DESNAKE_PCT * `DRDS_CLK_KHZ) / (100 * `DRDS_BIT_KHZ);
   localparam [3:0]   DLY_CYC = (DLY_RAW < 1) ? 4'h1 : DLY_RAW[3:0];
   localparam [3:0]   SMP_CYC = `DRDS_SAMPLE_CYC;

   // Mark sequencer states
   localparam [1:0] MS_IDLE = 2'b00;
   localparam [1:0] MS_HUNT = 2'b01;
   localparam [1:0] MS_TIME = 2'b10;

   // Register address decode, shared by read and write
   function [2:0] reg_idx;
      input [7:0] a;
      begin
         if (a == `DRDS_CTRL_OFS) begin
            reg_idx = 3'h1;
         end else if (a == `DRDS_STAT_OFS) begin
            reg_idx = 3'h2;
         end else if (a == `DRDS_LOCK_OFS) begin
            reg_idx = 3'h3;
         end else if (a == `DRDS_QUAL_OFS) begin
            reg_idx = 3'h4;
         end else if (a == `DRDS_MTIM_OFS) begin
            reg_idx = 3'h5;
         end else begin
            reg_idx = 3'h0;
         end
      end
   endfunction

   reg        read_cmd_r;
   reg        mark_cmd_r;
   reg [15:0] lock_cfg_r;
   reg [15:0] qual_cfg_r;
   reg [15:0] mtim_cfg_r;
   reg [1:0]  ms_state_r;
   reg [15:0] ms_cnt_r;
   reg [15:0] lock_cnt_r;
   reg        read_cmd_d_r;
   reg        cmp_d_r;
   reg [3:0]  dly_cnt_r;
   reg        desnake_r;
   reg        desnake_d_r;
   reg [15:0] acc_r;
   reg [3:0]  smp_cnt_r;
   reg [15:0] corr_cnt_r;
   reg        servo_d_r;

   wire       mark_search_mode = (ms_state_r == MS_HUNT);
   wire       fast_lock_enable = (lock_cnt_r != 16'h0000);
   wire       read_output_inhibit = fast_lock_enable;

   // ==========================================
   // AXI4-Lite slave: one write, one read at a time
   wire       wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire       rd_go = s_axi_arvalid & ~s_axi_rvalid;
   wire [2:0] wr_idx = reg_idx(s_axi_awaddr);
   wire [2:0] rd_idx = reg_idx(s_axi_araddr);
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   // Write side; mark command bit is a one-cycle strobe
   always @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DRDS_RESP_OK;
         read_cmd_r   <= 1'b0;
         mark_cmd_r   <= 1'b0;
         lock_cfg_r   <= LOCK_PRESET;
         qual_cfg_r   <= MARK_QUAL;
         mtim_cfg_r   <= MARK_TIME;
      end else begin
         mark_cmd_r <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == 3'h0) ? `DRDS_RESP_DECERR : `DRDS_RESP_OK;
            if (wr_idx == 3'h1 && s_axi_wstrb[0]) begin
               mark_cmd_r <= s_axi_wdata[`DRDS_CTRL_MARK];
               read_cmd_r <= s_axi_wdata[`DRDS_CTRL_READ];
            end
            if (wr_idx == 3'h3) begin
               if (s_axi_wstrb[0]) lock_cfg_r[7:0]  <= s_axi_wdata[7:0];
               if (s_axi_wstrb[1]) lock_cfg_r[15:8] <= s_axi_wdata[15:8];
            end
            if (wr_idx == 3'h4) begin
               if (s_axi_wstrb[0]) qual_cfg_r[7:0]  <= s_axi_wdata[7:0];
               if (s_axi_wstrb[1]) qual_cfg_r[15:8] <= s_axi_wdata[15:8];
            end
            if (wr_idx == 3'h5) begin
               if (s_axi_wstrb[0]) mtim_cfg_r[7:0]  <= s_axi_wdata[7:0];
               if (s_axi_wstrb[1]) mtim_cfg_r[15:8] <= s_axi_wdata[15:8];
            end
         end
      end
   end

   // Read side; status shows live sequencer state
   always @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `DRDS_RESP_OK;
      end else begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= (rd_idx == 3'h0) ? `DRDS_RESP_DECERR : `DRDS_RESP_OK;
            s_axi_rdata  <= 32'h00000000;
            if (rd_idx == 3'h1) begin
               s_axi_rdata[`DRDS_CTRL_READ] <= read_cmd_r;
            end else if (rd_idx == 3'h2) begin
               s_axi_rdata[`DRDS_ST_FOUND]  <= mark_found_flag;
               s_axi_rdata[`DRDS_ST_SEARCH] <= mark_search_mode;
               s_axi_rdata[`DRDS_ST_FAST]   <= fast_lock_enable;
               s_axi_rdata[`DRDS_ST_INHIB]  <= read_output_inhibit;
               s_axi_rdata[`DRDS_ST_F]      <= clk_f;
            end else if (rd_idx == 3'h3) begin
               s_axi_rdata[15:0] <= lock_cfg_r;
            end else if (rd_idx == 3'h4) begin
               s_axi_rdata[15:0] <= qual_cfg_r;
            end else if (rd_idx == 3'h5) begin
               s_axi_rdata[15:0] <= mtim_cfg_r;
            end
         end
      end
   end

   // ==========================================
   // Crossover digitizer
   // gate: read window, not while hunting or timing a mark
   wire dig_en = read_window_gate & (ms_state_r == MS_IDLE);
   // either comparator edge, one pulse stream
   wire edge_p = (cmp_out ^ cmp_d_r);
   wire raw_read_pulses = desnake_r ^ desnake_d_r;

   // Delayed sample rejects snakes between true transitions
   always @(posedge clk) begin
      if (rst) begin
         cmp_d_r     <= 1'b0;
         dly_cnt_r   <= 4'h0;
         desnake_r   <= 1'b0;
         desnake_d_r <= 1'b0;
      end else begin
         cmp_d_r     <= cmp_out;
         desnake_d_r <= desnake_r;
         if (!dig_en) begin
            dly_cnt_r <= 4'h0;
         end else if (edge_p) begin
            dly_cnt_r <= DLY_CYC;
         end else if (dly_cnt_r != 4'h0) begin
            dly_cnt_r <= dly_cnt_r - 4'h1;
         end
         // comparator level taken at delayed clock
         if (dig_en && dly_cnt_r == 4'h1) begin
            desnake_r <= cmp_out;
         end
      end
   end

   // ==========================================
   // Address mark sequencer and lock-up counter
   // Quiet line (no crossover) during hunt marks the mark area
   always @(posedge clk) begin
      if (rst) begin
         ms_state_r      <= MS_IDLE;
         ms_cnt_r        <= 16'h0000;
         mark_found_flag <= 1'b0;
         lock_cnt_r      <= 16'h0000;
         read_cmd_d_r    <= 1'b0;
      end else begin
         read_cmd_d_r <= read_cmd_r;
         case (ms_state_r)
            MS_IDLE: begin
               mark_found_flag <= 1'b0;
               if (mark_cmd_r) begin
                  ms_state_r <= MS_HUNT;
                  ms_cnt_r   <= 16'h0000;
               end
            end
            MS_HUNT: begin
               if (edge_p) begin
                  ms_cnt_r <= 16'h0000;
               end else if (ms_cnt_r + 16'h0001 >= qual_cfg_r) begin
                  ms_state_r      <= MS_TIME;
                  ms_cnt_r        <= mtim_cfg_r;
                  mark_found_flag <= 1'b1;
               end else begin
                  ms_cnt_r <= ms_cnt_r + 16'h0001;
               end
            end
            MS_TIME: begin
               // search dropped; timing cycle runs out
               if (ms_cnt_r <= 16'h0001) begin
                  ms_state_r      <= MS_IDLE;
                  mark_found_flag <= 1'b0;
               end else begin
                  ms_cnt_r <= ms_cnt_r - 16'h0001;
               end
            end
            default: begin
               ms_state_r <= MS_IDLE;
            end
         endcase
         // load at mark detect, or at read start
         if (ms_state_r == MS_HUNT && mark_found_flag == 1'b0 && !edge_p &&
             ms_cnt_r + 16'h0001 >= qual_cfg_r) begin
            lock_cnt_r <= lock_cfg_r;
         end else if (read_cmd_r && !read_cmd_d_r && ms_state_r == MS_IDLE) begin
            lock_cnt_r <= lock_cfg_r;
         end else if (!read_cmd_r) begin
            lock_cnt_r <= 16'h0000;
         end else if (lock_cnt_r != 16'h0000) begin
            lock_cnt_r <= lock_cnt_r - 16'h0001;
         end
      end
   end

   // ==========================================
   // Recovered oscillator and phase detector
   // loop input: read pulses when reading, else servo while heads loaded
   wire servo_edge = servo_reference_osc & ~servo_d_r;
   wire loop_in = read_cmd_r ? raw_read_pulses : (servo_edge & heads_loaded);
   // 2F phase normally, F and 2F phase in fast lock
   wire [15:0] ph_err = fast_lock_enable ? {clk_f, acc_r[15:1]} : acc_r;
   wire        err_neg = ph_err[15];
   wire [15:0] err_mag = err_neg ? (16'h0000 - ph_err) : ph_err;
   // fast lock removes full error, normal lock a fraction
   wire [15:0] step = fast_lock_enable ? err_mag : (err_mag >> `DRDS_GAIN_SHIFT);
   wire        smp_open = (smp_cnt_r != 4'h0);
   wire [15:0] acc_adv = acc_r + FREQ_WORD;
   wire [15:0] acc_nxt = (loop_in && smp_open) ?
                         (err_neg ? acc_adv + step : acc_adv - step) : acc_adv;

   // Phase accumulator; frequency word never altered by the loop
   always @(posedge clk) begin
      if (rst) begin
         acc_r     <= 16'h0000;
         servo_d_r <= 1'b0;
         smp_cnt_r <= 4'h0;
      end else begin
         // accumulator rate is twice bit rate
         acc_r     <= acc_nxt;
         servo_d_r <= servo_reference_osc;
         // sample window opens only near a cell edge
         if (!acc_r[15] && acc_nxt[15]) begin
            smp_cnt_r <= SMP_CYC;
         end else if (smp_open) begin
            smp_cnt_r <= smp_cnt_r - 4'h1;
         end
      end
   end

   // Correction pulse, width follows error magnitude
   always @(posedge clk) begin
      if (rst) begin
         corr_cnt_r       <= 16'h0000;
         correction_pulse <= 1'b0;
         correction_up    <= 1'b0;
      end else begin
         if (loop_in && smp_open) begin
            corr_cnt_r    <= err_mag >> 8;
            correction_up <= err_neg;
         end else if (corr_cnt_r != 16'h0000) begin
            corr_cnt_r <= corr_cnt_r - 16'h0001;
         end
         correction_pulse <= (loop_in && smp_open) ? ((err_mag >> 8) != 16'h0000)
                             : (corr_cnt_r > 16'h0001);
      end
   end

   // ==========================================
   // Clock divider and data output
   wire rise_2f = ~acc_r[15] & acc_nxt[15];
   wire f_nxt = rise_2f ? ~clk_f : clk_f;

   always @(posedge clk) begin
      if (rst) begin
         clk_2f              <= 1'b0;
         clk_2f_n            <= 1'b1;
         clk_f               <= 1'b0;
         clk_f_n             <= 1'b1;
         rw_clock            <= 1'b0;
         phase_compare_clock <= 1'b0;
         read_data_out       <= 1'b0;
      end else begin
         clk_2f   <= acc_nxt[15];
         clk_2f_n <= ~acc_nxt[15];
         clk_f    <= f_nxt;
         clk_f_n  <= ~f_nxt;
         rw_clock <= f_nxt;
         phase_compare_clock <= fast_lock_enable ? (f_nxt & acc_nxt[15]) : acc_nxt[15];
         // data only after lock-up, read active
         // zero field spent locking before data passes
         read_data_out <= read_cmd_r & ~read_output_inhibit & raw_read_pulses;
      end
   end

endmodule
`default_nettype wire

/* File: rtl/drds_defs.vh */
// Constants for the disk read data recovery and sync block
`ifndef DRDS_DEFS_VH
`define DRDS_DEFS_VH
// ==========================================
// Register byte offsets
`define DRDS_CTRL_OFS      8'h00
`define DRDS_STAT_OFS      8'h04
`define DRDS_LOCK_OFS      8'h08
`define DRDS_QUAL_OFS      8'h0C
`define DRDS_MTIM_OFS      8'h10
// ==========================================
// Field positions
`define DRDS_CTRL_MARK     0
`define DRDS_CTRL_READ     1
`define DRDS_ST_FOUND      0
`define DRDS_ST_SEARCH     1
`define DRDS_ST_FAST       2
`define DRDS_ST_INHIB      3
`define DRDS_ST_F          4
// ==========================================
// Reset values
`define DRDS_LOCK_RST      16'h0040
`define DRDS_QUAL_RST      16'h0010
`define DRDS_MTIM_RST      16'h0100
// ==========================================
// Timing: clock and bit rate in kHz
`define DRDS_CLK_KHZ       40000
`define DRDS_BIT_KHZ       6450
`define DRDS_DESNAKE_PCT   40
// Oscillator tuning word, 2F / clk * 65536
`define DRDS_FREQ_WORD     16'h528F
`define DRDS_SAMPLE_CYC    4'h2
`define DRDS_GAIN_SHIFT    2
// ==========================================
// Bus responses
`define DRDS_RESP_OK       2'h0
`define DRDS_RESP_DECERR   2'h3
`endif

/* File: testbench/disk_read_data_recovery_sync_tb_top.sv */
// Self-checking bench for the read recovery block
`include "drds_defs.vh"
`default_nettype none
module disk_read_data_recovery_sync_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic        cmp_out, read_window_gate, heads_loaded, mark_found_flag, read_data_out, rw_clock;
   logic        clk_2f, clk_2f_n, clk_f, clk_f_n, phase_compare_clock, correction_pulse, correction_up;
   logic        sync_found, mark_seen;
   logic [15:0] bit_count, servo_acc;
   wire         servo_reference_osc = servo_acc[15];
   int          failures = 0;
   int          comparisons = 0;
   drds_core #(.LOCK_PRESET(16'h0010), .MARK_QUAL(16'h0004), .MARK_TIME(16'h0008)) i_drds_core (.clk, .rst,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cmp_out, .read_window_gate, .servo_reference_osc,
      .heads_loaded, .mark_found_flag, .read_data_out, .rw_clock, .clk_2f, .clk_2f_n, .clk_f, .clk_f_n,
      .phase_compare_clock, .correction_pulse, .correction_up);
   drds_ctrl_model i_drds_ctrl_model (.clk, .rst, .read_data_out, .mark_found_flag, .bit_count,
      .sync_found, .mark_seen);
   // ==========================================
   // Clock and a servo reference near the 2F rate
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      servo_acc <= servo_acc + 16'h528F;
   end
   // ==========================================
   // Shared helpers
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // Address and data offered together, each released on its own ready
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk);
         if (s_axi_awready && !aw_done) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w_done) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Ready for the answer from the start, taken at the edge it is seen
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Comparator edges spaced so each bit drains the pipeline
   task automatic toggle(input int n);
      repeat (n) begin
         @(posedge clk);
         cmp_out <= ~cmp_out;
         repeat (5) @(posedge clk);
      end
      repeat (6) @(posedge clk);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      repeat (12) @(posedge clk);
      chk("clk_f_n in reset", 32'h1, {31'h0, clk_f_n});
      rst <= 1'b0;
      axi_rd(`DRDS_STAT_OFS, rd, rs);
      chk("status after reset", 32'h0, rd & 32'h0000000F);
   endtask
   task automatic t_bus;
      axi_wr(`DRDS_LOCK_OFS, 32'h00000010, rs);
      chk("lock write resp", 32'h0, {30'h0, rs});
      axi_rd(`DRDS_LOCK_OFS, rd, rs);
      chk("lock readback", 32'h00000010, rd);
      axi_wr(`DRDS_QUAL_OFS, 32'h00000004, rs);
      axi_wr(`DRDS_MTIM_OFS, 32'h00000040, rs);
      axi_rd(8'h20, rd, rs);
      chk("unmapped read resp", 32'h3, {30'h0, rs});
      axi_wr(8'h20, 32'h0000FFFF, rs);
      chk("unmapped write resp", 32'h3, {30'h0, rs});
   endtask
   // Free-running rate of 2F and F, counted over 400 cycles
   task automatic t_clocks;
      int n2, nf, e;
      logic p2, pf;
      n2 = 0;
      nf = 0;
      p2 = 1'b1;
      pf = 1'b1;
      e = 400 * 2 * `DRDS_BIT_KHZ / `DRDS_CLK_KHZ;
      heads_loaded <= 1'b0;
      repeat (400) begin
         @(posedge clk);
         n2 += int'(clk_2f && !clk_2f_n && !p2);
         nf += int'(clk_f && !pf);
         p2 = clk_2f;
         pf = clk_f;
      end
      chk("2F rises in window", 32'h1, {31'h0, n2 >= e - 2 && n2 <= e + 2});
      chk("F rises in window", 32'h1, {31'h0, nf >= e / 2 - 2 && nf <= e / 2 + 2});
      // No loop input with heads unloaded and read off, so no correction
      chk("correction with loop idle", 32'h0, {31'h0, correction_pulse});
      heads_loaded <= 1'b1;
   endtask
   task automatic t_mark;
      int n;
      logic [15:0] b;
      n = 0;
      axi_wr(`DRDS_CTRL_OFS, 32'h00000002, rs);
      axi_wr(`DRDS_CTRL_OFS, 32'h00000003, rs);
      while (!mark_found_flag && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("mark flag raised", 32'h1, {31'h0, mark_found_flag});
      axi_rd(`DRDS_STAT_OFS, rd, rs);
      // Found, search dropped, fast lock and inhibit while counting
      chk("status mark found", 32'hD, rd & 32'h0000000F);
      b = bit_count;
      toggle(4);
      chk("bits during mark timing", {16'h0, b}, {16'h0, bit_count});
      chk("controller saw flag", 32'h1, {31'h0, mark_seen});
      n = 0;
      while (mark_found_flag && n < 300) begin
         @(posedge clk);
         n++;
      end
      repeat (40) @(posedge clk);
      b = bit_count;
      toggle(8);
      chk("bits after lock-up", {16'h0, b + 16'h0008}, {16'h0, bit_count});
      chk("sync byte found", 32'h1, {31'h0, sync_found});
   endtask
   task automatic t_gating;
      logic [15:0] b;
      axi_wr(`DRDS_CTRL_OFS, 32'h00000000, rs);
      b = bit_count;
      toggle(4);
      chk("bits with read off", {16'h0, b}, {16'h0, bit_count});
      axi_wr(`DRDS_CTRL_OFS, 32'h00000002, rs);
      repeat (40) @(posedge clk);
      read_window_gate <= 1'b0;
      toggle(4);
      chk("bits with gate low", {16'h0, b}, {16'h0, bit_count});
      read_window_gate <= 1'b1;
      toggle(3);
      chk("bits without marks", {16'h0, b + 16'h0003}, {16'h0, bit_count});
   endtask
   // ==========================================
   // Verdict and run control
   task automatic end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      cmp_out = 1'b0;
      read_window_gate = 1'b1;
      heads_loaded = 1'b1;
      servo_acc = 16'h0000;
      t_reset();
      t_bus();
      t_clocks();
      t_mark();
      t_gating();
      end_sim();
   end
   // Watchdog well past the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("mismatch watchdog expected finish seen timeout");
      end_sim();
   end
endmodule
`default_nettype wire

/* File: testbench/drds_core_properties.sv */
// Port timing checker for the read recovery block
`default_nettype none
module drds_core_properties (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        cmp_out,
   input wire logic        read_window_gate,
   input wire logic        mark_found_flag,
   input wire logic        read_data_out,
   input wire logic        rw_clock,
   input wire logic        clk_f,
   input wire logic        clk_f_n,
   input wire logic        clk_2f,
   input wire logic        phase_compare_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // Assertions, one clock domain
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   flag_blocks_data_a: assert property (mark_found_flag |-> !read_data_out)
      else $error("data bit during mark timing");
   flag_span_a: assert property ($rose(mark_found_flag) |-> mark_found_flag[*3] ##[1:300] !mark_found_flag)
      else $error("mark flag span wrong");
   quiet_before_mark_a: assert property ($rose(mark_found_flag) |-> $past(cmp_out, 2) == $past(cmp_out, 3))
      else $error("mark flagged on active line");
   gate_low_quiet_a: assert property ((!read_window_gate)[*5] |-> !read_data_out)
      else $error("data bit with window gate low");
   bit_needs_edge_a: assert property (read_data_out |-> $past(cmp_out, 4) != $past(cmp_out, 5))
      else $error("data bit without comparator edge");
   f_complement_a: assert property (clk_f_n == !clk_f)
      else $error("bit clock complement wrong");
   rw_clock_f_a: assert property (rw_clock == clk_f)
      else $error("read write clock differs from bit clock");
   phase_clk_2f_a: assert property (phase_compare_clock |-> clk_2f || $past(clk_2f))
      else $error("phase clock outside 2F high");
   resp_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h10
      |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule
bind drds_core drds_core_properties i_drds_core_properties (.clk, .rst, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rdata, .s_axi_rresp, .cmp_out, .read_window_gate,
   .mark_found_flag, .read_data_out, .rw_clock, .clk_f, .clk_f_n, .clk_2f, .phase_compare_clock);
`default_nettype wire

/* File: testbench/drds_ctrl_model.sv */
// Disk controller model: counts recovered bits and hunts the sync byte
`default_nettype none
module drds_ctrl_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        read_data_out,
   input  wire logic        mark_found_flag,
   output var  logic [15:0] bit_count,
   output var  logic        sync_found,
   output var  logic        mark_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // sync byte hunt
   // Only ones arrive as pulses, so eight bits make the sync byte
   always @(posedge clk) begin
      if (rst) begin
         bit_count <= 16'h0000;
         sync_found <= 1'b0;
         mark_seen <= 1'b0;
      end else begin
         if (read_data_out) begin
            bit_count <= bit_count + 16'h0001;
         end
         if (read_data_out && bit_count == 16'h0007) begin
            sync_found <= 1'b1;
         end
         if (mark_found_flag) begin
            mark_seen <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire
